// ===== hdl/pstpc_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; out_data is valid whenever out_valid is high
`timescale 1ns/100ps
module pstpc_fifo #(
  parameter int WIDTH = 7,   // word width
  parameter int DEPTH = 16   // number of words, power of two
) (
  input  wire logic             clk,        // core clock
  input  wire logic             rst_n,      // async reset, active low
  input  wire logic             in_valid,   // writer offers a word
  output logic                  in_ready,   // room for a word
  input  wire logic [WIDTH-1:0] in_data,    // word written
  output logic                  out_valid,  // a word is held
  input  wire logic             out_ready,  // reader takes the word
  output logic      [WIDTH-1:0] out_data    // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW:0]      wr_ptr_r;     // write pointer with wrap bit
  logic [AW:0]      rd_ptr_r;     // read pointer with wrap bit
  logic [AW:0]      wr_ptr_nxt;   // next write pointer
  logic [AW:0]      rd_ptr_nxt;   // next read pointer
  logic             do_wr;        // word accepted
  logic             do_rd;        // word removed

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // pointer advance
  always_comb begin
    wr_ptr_nxt = do_wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = do_rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  // pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule // pstpc_fifo

// ===== hdl/pstpc_lfsr.sv
// pseudo-random nibble source, four shifts per step
// assumes step is a single-cycle request from the same clock
`timescale 1ns/100ps
`include "pstpc_regs.svh"
module pstpc_lfsr #(
  parameter int WIDTH = 15  // shift register length
) (
  input  wire logic       clk,     // core clock
  input  wire logic       rst_n,   // async reset, active low
  input  wire logic       step,    // advance by one nibble
  output logic      [3:0] nibble   // current nibble
);
  logic [WIDTH-1:0] sr_r;    // shift register
  logic [WIDTH-1:0] sr_nxt;  // next shift register

  assign nibble = sr_r[3:0];

  // four shifts of x^15 + x^14 + 1 per step
  always_comb begin
    sr_nxt = sr_r;
    if (step) begin
      for (int i = 0; i < 4; i++) begin
        sr_nxt = {sr_nxt[WIDTH-2:0], sr_nxt[WIDTH-1] ^ sr_nxt[WIDTH-2]};
      end
    end
  end

  // register, seeded nonzero so it never locks up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= WIDTH'(`PSTPC_LFSR_SEED);
    end else begin
      sr_r <= sr_nxt;
    end
  end
endmodule // pstpc_lfsr

// ===== hdl/pstpc_pkg.sv
// types shared by the self-test and pattern generator files
// assumes nothing of its surroundings
package pstpc_pkg;

  // generator states, one-hot
  typedef enum logic [2:0] {
    GEN_IDLE = 3'h1,  // nothing in progress
    GEN_SEND = 3'h2,  // emitting a sequence
    GEN_GAP  = 3'h4   // idle gap between sequences
  } pstpc_gen_state_t;

  // kind of each word handed to the transmitter
  typedef enum logic [2:0] {
    KIND_DATA  = 3'h0,  // scrambled data nibble
    KIND_END_A = 3'h1,  // end of packet, first form
    KIND_END_B = 3'h2,  // end of packet, second form
    KIND_LINK  = 3'h3,  // one normal link pulse
    KIND_ONES  = 3'h4   // manchester ones, tone
  } pstpc_kind_t;

endpackage

// ===== hdl/pstpc_regs.svh
// offsets, field positions, reset values and timing counts of the self-test block
// assumes a 5-bit management register address and a 250 MHz core clock
`ifndef PSTPC_REGS_SVH
`define PSTPC_REGS_SVH

// register offset on the management address space
`define PSTPC_CTRL_ADDR      5'h1B
`define PSTPC_CTRL_RST      16'h0000
// field positions
`define PSTPC_ERR_CNT_MSB    15
`define PSTPC_ERR_CNT_LSB    8
`define PSTPC_CONT_BIT       5
`define PSTPC_PAT_EN_BIT     4
`define PSTPC_GAP_SEL_BIT    2
`define PSTPC_SEL_MSB        1
`define PSTPC_SEL_LSB        0
// pattern select codes
`define PSTPC_SEL_DATA_A     2'h0
`define PSTPC_SEL_DATA_B     2'h1
`define PSTPC_SEL_LINK       2'h2
`define PSTPC_SEL_TONE       2'h3
// timing: gap times in microseconds and the core clock rate
`define PSTPC_CLK_MHZ        250
`define PSTPC_GAP_SHORT_US   10
`define PSTPC_GAP_LONG_US    15
`define PSTPC_GAP_SHORT_CYC  (`PSTPC_GAP_SHORT_US * `PSTPC_CLK_MHZ)
`define PSTPC_GAP_LONG_CYC   (`PSTPC_GAP_LONG_US * `PSTPC_CLK_MHZ)
// scrambler seed
`define PSTPC_LFSR_SEED     15'h7FFF

`endif

// ===== hdl/pstpc_top.sv
// self-test error counter, continuous scrambled stream and 10 Mb/s test patterns
// assumes bist_start/bist_active come from the phy control register logic and
// rx nibble flags and tx_ready come from logic on the same clock
`timescale 1ns/100ps
`include "pstpc_regs.svh"
// Overview of operation
// - count errored nibbles during self test, bits 15:8
// - counter clears when self test restarts
// - counter sticks at its maximum
// - continuous bit streams scrambled data gaplessly
// - continuous mode needs self test running too
// - bit 4 enables the 10 Mb/s pattern generator
// - bit 2 picks 15 or 10 us gap
// - select picks data/end form a, b, link pulses
// - select 11 sends endless manchester ones tone
module pstpc_top #(
  parameter int SEQ_LEN    = 16,  // data nibbles per test sequence
  parameter int FIFO_DEPTH = 16   // words buffered toward the transmitter
) (
  input  wire logic        clk,             // core clock, 250 MHz
  input  wire logic        rst_n,           // async reset, active low
  input  wire logic [4:0]  reg_addr,        // management register address
  input  wire logic        reg_wr,          // write strobe, one cycle
  input  wire logic        reg_rd,          // read strobe, one cycle
  input  wire logic [15:0] reg_wdata,       // write data
  output logic      [15:0] reg_rdata,       // read data, one cycle after reg_rd
  input  wire logic        bist_start,      // self test (re)started, pulse
  input  wire logic        bist_active,     // self test running, level
  input  wire logic        rx_nibble_valid, // received nibble checked
  input  wire logic        rx_nibble_error, // that nibble was in error
  output logic             tx_valid,        // word offered to transmitter
  input  wire logic        tx_ready,        // transmitter takes the word
  output logic      [2:0]  tx_kind,         // word kind
  output logic      [3:0]  tx_nibble,       // word data
  output logic             cont_prbs_active // continuous stream running
);
  localparam int GW = 12;  // gap counter width
  localparam int SW = $clog2(SEQ_LEN + 1);
  localparam logic [GW-1:0] GAP_SHORT = GW'(`PSTPC_GAP_SHORT_CYC - 1);
  localparam logic [GW-1:0] GAP_LONG  = GW'(`PSTPC_GAP_LONG_CYC - 1);

  // control fields
  logic        cont_r, cont_nxt;          // continuous mode bit
  logic        pat_en_r, pat_en_nxt;      // pattern generator enable
  logic        gap_sel_r, gap_sel_nxt;    // long gap select
  logic [1:0]  sel_r, sel_nxt;            // pattern select
  logic [7:0]  err_cnt_r, err_cnt_nxt;    // errored nibble counter
  logic [15:0] rdata_r, rdata_nxt;        // read data
  logic        ctrl_hit;                  // address matches the register

  // generator state
  pstpc_pkg::pstpc_gen_state_t gen_state_r, gen_state_nxt;
  logic [SW-1:0] seq_cnt_r, seq_cnt_nxt;  // nibbles sent in sequence
  logic [GW-1:0] gap_cnt_r, gap_cnt_nxt;  // gap cycles left
  logic          push;                    // word into fifo
  pstpc_pkg::pstpc_kind_t push_kind;      // kind of that word
  logic          cont_run;                // continuous stream allowed
  logic          cont_nxt_out;            // next value of status output

  // fifo and output stage
  logic       fifo_in_ready;   // fifo has room
  logic       fifo_out_valid;  // fifo holds a word
  logic       fifo_pop;        // move word to output stage
  logic [6:0] fifo_out_data;   // oldest word
  logic [3:0] prbs_nibble;     // scrambled nibble
  logic       out_valid_r, out_valid_nxt;  // output stage full
  logic [6:0] out_word_r, out_word_nxt;    // output stage word

  assign ctrl_hit = (reg_addr == `PSTPC_CTRL_ADDR);

  // register file and error counter next values
  always_comb begin
    cont_nxt    = cont_r;
    pat_en_nxt  = pat_en_r;
    gap_sel_nxt = gap_sel_r;
    sel_nxt     = sel_r;
    err_cnt_nxt = err_cnt_r;
    rdata_nxt   = rdata_r;
    if (reg_wr && ctrl_hit) begin  // only writable bits are stored
      cont_nxt    = reg_wdata[`PSTPC_CONT_BIT];
      pat_en_nxt  = reg_wdata[`PSTPC_PAT_EN_BIT];
      gap_sel_nxt = reg_wdata[`PSTPC_GAP_SEL_BIT];
      sel_nxt     = reg_wdata[`PSTPC_SEL_MSB:`PSTPC_SEL_LSB];
    end
    if (bist_start) begin  // restart clears the count
      err_cnt_nxt = 8'h00;
    end else if (bist_active && rx_nibble_valid && rx_nibble_error
                 && (err_cnt_r != 8'hFF)) begin  // count, stick at max
      err_cnt_nxt = err_cnt_r + 8'h01;
    end
    if (reg_rd) begin  // reserved bits and other addresses read zero
      rdata_nxt = 16'h0000;
      if (ctrl_hit) begin
        rdata_nxt[`PSTPC_ERR_CNT_MSB:`PSTPC_ERR_CNT_LSB] = err_cnt_r;
        rdata_nxt[`PSTPC_CONT_BIT]    = cont_r;
        rdata_nxt[`PSTPC_PAT_EN_BIT]  = pat_en_r;
        rdata_nxt[`PSTPC_GAP_SEL_BIT] = gap_sel_r;
        rdata_nxt[`PSTPC_SEL_MSB:`PSTPC_SEL_LSB] = sel_r;
      end
    end
  end

  // register file and error counter registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cont_r    <= 1'((`PSTPC_CTRL_RST >> `PSTPC_CONT_BIT) & 16'h0001);
      pat_en_r  <= 1'((`PSTPC_CTRL_RST >> `PSTPC_PAT_EN_BIT) & 16'h0001);
      gap_sel_r <= 1'((`PSTPC_CTRL_RST >> `PSTPC_GAP_SEL_BIT) & 16'h0001);
      sel_r     <= 2'(`PSTPC_CTRL_RST & 16'h0003);
      err_cnt_r <= 8'h00;
      rdata_r   <= 16'h0000;
    end else begin
      cont_r    <= cont_nxt;
      pat_en_r  <= pat_en_nxt;
      gap_sel_r <= gap_sel_nxt;
      sel_r     <= sel_nxt;
      err_cnt_r <= err_cnt_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // continuous stream only while self test runs and pattern generator is off
  assign cont_run     = cont_r && bist_active && !pat_en_r;
  assign cont_nxt_out = cont_run;

  // generator next state and fifo push
  always_comb begin
    gen_state_nxt = gen_state_r;
    seq_cnt_nxt   = seq_cnt_r;
    gap_cnt_nxt   = gap_cnt_r;
    push          = 1'b0;
    push_kind     = pstpc_pkg::KIND_DATA;
    if (!pat_en_r) begin  // generator disabled
      gen_state_nxt = pstpc_pkg::GEN_IDLE;
      seq_cnt_nxt   = '0;
      if (cont_run && fifo_in_ready) begin  // gapless scrambled data
        push = 1'b1;
      end
    end else begin
      unique case (gen_state_r)
        pstpc_pkg::GEN_IDLE: begin
          seq_cnt_nxt   = '0;
          gen_state_nxt = pstpc_pkg::GEN_SEND;
        end
        pstpc_pkg::GEN_SEND: begin
          if (fifo_in_ready) begin
            push = 1'b1;
            if (sel_r == `PSTPC_SEL_TONE) begin  // endless ones, no gap
              push_kind = pstpc_pkg::KIND_ONES;
            end else if (sel_r == `PSTPC_SEL_LINK) begin  // one pulse
              push_kind     = pstpc_pkg::KIND_LINK;
              gen_state_nxt = pstpc_pkg::GEN_GAP;
            end else if (seq_cnt_r != SW'(SEQ_LEN)) begin  // data nibbles
              push_kind   = pstpc_pkg::KIND_DATA;
              seq_cnt_nxt = seq_cnt_r + 1'b1;
            end else begin  // closing end-of-packet form
              push_kind = (sel_r == `PSTPC_SEL_DATA_B) ? pstpc_pkg::KIND_END_B
                                                       : pstpc_pkg::KIND_END_A;
              gen_state_nxt = pstpc_pkg::GEN_GAP;
            end
            if (gen_state_nxt == pstpc_pkg::GEN_GAP) begin  // load gap length
              gap_cnt_nxt = gap_sel_r ? GAP_LONG : GAP_SHORT;
            end
          end
        end
        pstpc_pkg::GEN_GAP: begin
          if (gap_cnt_r == '0) begin
            gen_state_nxt = pstpc_pkg::GEN_IDLE;
          end else begin
            gap_cnt_nxt = gap_cnt_r - 1'b1;
          end
        end
        default: begin  // illegal code recovers to idle
          gen_state_nxt = pstpc_pkg::GEN_IDLE;
        end
      endcase
    end
  end

  // generator registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_state_r      <= pstpc_pkg::GEN_IDLE;
      seq_cnt_r        <= '0;
      gap_cnt_r        <= '0;
      cont_prbs_active <= 1'b0;
    end else begin
      gen_state_r      <= gen_state_nxt;
      seq_cnt_r        <= seq_cnt_nxt;
      gap_cnt_r        <= gap_cnt_nxt;
      cont_prbs_active <= cont_nxt_out;
    end
  end

  // scrambler advances on each data word pushed
  pstpc_lfsr #(.WIDTH(15)) u_lfsr (
    .clk    (clk),
    .rst_n  (rst_n),
    .step   (push && (push_kind == pstpc_pkg::KIND_DATA)),
    .nibble (prbs_nibble)
  );

  // buffer toward the transmitter; a stalled transmitter stalls the generator
  pstpc_fifo #(.WIDTH(7), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_kind, (push_kind == pstpc_pkg::KIND_DATA) ? prbs_nibble : 4'hF}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // output stage refills when empty or being taken
  assign fifo_pop = fifo_out_valid && (!out_valid_r || tx_ready);

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_word_nxt  = out_word_r;
    if (fifo_pop) begin
      out_valid_nxt = 1'b1;
      out_word_nxt  = fifo_out_data;
    end else if (tx_ready) begin
      out_valid_nxt = 1'b0;
    end
  end

  // output stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_word_r  <= 7'h00;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_word_r  <= out_word_nxt;
    end
  end

  assign tx_valid  = out_valid_r;
  assign tx_kind   = out_word_r[6:4];
  assign tx_nibble = out_word_r[3:0];
  assign reg_rdata = rdata_r;

  // checks, all on the core clock and quiet while reset is low
  // consequents look at what this block drives, and AST_CONT_NEEDS_BIST also at bist_active
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // error counter checks
  AST_ERR_COUNT_INC: assert property (
    bist_active && rx_nibble_valid && rx_nibble_error && !bist_start && err_cnt_r != 8'hFF
    |=> err_cnt_r == $past(err_cnt_r) + 8'h01)
    else $error("error count did not advance");
  AST_ERR_CLEAR: assert property (
    bist_start |=> err_cnt_r == 8'h00)
    else $error("error count not cleared on restart");
  AST_ERR_SATURATE: assert property (
    err_cnt_r == 8'hFF && !bist_start |=> err_cnt_r == 8'hFF)
    else $error("error count wrapped");
  AST_ERR_IDLE: assert property (
    !bist_active && !bist_start |=> err_cnt_r == $past(err_cnt_r))
    else $error("error counted outside self test");

  // stream generator checks
  AST_CONT_GAPLESS: assert property (
    cont_r && bist_active && !pat_en_r && fifo_in_ready |-> push)
    else $error("continuous stream interrupted");
  AST_CONT_NEEDS_BIST: assert property (
    push && !pat_en_r |-> cont_r && bist_active)
    else $error("continuous stream without self test");
  AST_PAT_DISABLED: assert property (
    !pat_en_r |=> gen_state_r == pstpc_pkg::GEN_IDLE)
    else $error("generator active while disabled");
  AST_GAP_LENGTH: assert property (
    gen_state_r != pstpc_pkg::GEN_GAP && gen_state_nxt == pstpc_pkg::GEN_GAP
    |=> gap_cnt_r == ($past(gap_sel_r) ? GAP_LONG : GAP_SHORT))
    else $error("wrong gap length loaded");
  AST_END_FORM: assert property (
    push && push_kind == pstpc_pkg::KIND_END_B |-> sel_r == `PSTPC_SEL_DATA_B)
    else $error("end form b sent with wrong select");
  AST_TONE: assert property (
    pat_en_r && sel_r == `PSTPC_SEL_TONE && gen_state_r == pstpc_pkg::GEN_SEND
    && fifo_in_ready |-> push && push_kind == pstpc_pkg::KIND_ONES)
    else $error("tone stream broken");
  AST_LINK_SEL: assert property (
    push && push_kind == pstpc_pkg::KIND_LINK |-> pat_en_r && sel_r == `PSTPC_SEL_LINK)
    else $error("link pulse sent with wrong select");

  // transmit stream and read-back checks
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_kind) && $stable(tx_nibble))
    else $error("offered word changed before it was taken");
  AST_RDATA_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // main scenarios worth seeing
  COV_SATURATE: cover property (err_cnt_r == 8'hFF);
  COV_GAP:      cover property (gen_state_r == pstpc_pkg::GEN_GAP && gap_cnt_r == '0);
  COV_TONE:     cover property (push && push_kind == pstpc_pkg::KIND_ONES);
  COV_CONT:     cover property (cont_prbs_active && tx_valid && tx_ready);
  COV_END_B:    cover property (push && push_kind == pstpc_pkg::KIND_END_B);
endmodule // pstpc_top

// ===== test/pstpc_tx_partner.sv
// partner model: the transmitter that takes words off the tx stream
// assumes tx_valid comes from a registered source on the same clock
`timescale 1ns/100ps
module pstpc_tx_partner (
  input  wire logic clk,      // core clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic slow,     // take words only now and then
  input  wire logic stall,    // refuse every word
  input  wire logic tx_valid, // word offered
  output logic      tx_ready, // word taken at the next edge
  output int        taken     // words taken so far
);
  logic [7:0] pace_r; // private pacing pattern

  // ready moves at the falling edge only, clear of the sampling edge
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_r   <= 8'hA5;
      tx_ready <= 1'b0;
    end else begin
      pace_r   <= {pace_r[6:0], pace_r[7] ^ pace_r[5] ^ pace_r[4] ^ pace_r[3]};
      tx_ready <= !stall && (!slow || pace_r[0]);
    end
  end

  // count transfers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 0;
    end else if (tx_valid && tx_ready) begin
      taken <= taken + 1;
    end
  end
endmodule // pstpc_tx_partner

// ===== test/test_packet_self_test_pattern_control.sv
// self-checking bench for the self-test counter and pattern generator
// assumes the design files and the partner model are compiled first
`timescale 1ns/100ps
module test_packet_self_test_pattern_control;
  logic        clk = 1'b0;        // core clock
  logic        rst_n = 1'b0;      // reset, active low
  logic [4:0]  reg_addr = 5'h00;  // register address
  logic        reg_wr = 1'b0;     // write strobe
  logic        reg_rd = 1'b0;     // read strobe
  logic [15:0] reg_wdata = 16'h0000; // write data
  logic [15:0] reg_rdata;         // read data
  logic        bist_start = 1'b0; // self test restart
  logic        bist_active = 1'b0; // self test running
  logic        rx_nibble_valid = 1'b0; // nibble checked
  logic        rx_nibble_error = 1'b0; // nibble errored
  logic        tx_valid, tx_ready, cont_prbs_active; // stream and status
  logic [2:0]  tx_kind;           // word kind
  logic [3:0]  tx_nibble;         // word data
  logic        slow = 1'b0;       // partner pacing
  logic        stall = 1'b0;      // partner refusal
  logic        rd_pend = 1'b0;    // read answer due
  logic [15:0] lfsr_r = 16'hEC7A; // random source
  logic [14:0] scr_r = 15'h7FFF;  // scrambler model, x^15 + x^14 + 1
  logic [15:0] rd_q[$];           // expected read data
  logic [2:0]  tx_q[$];           // expected word kinds
  int          taken, failures = 0, checks = 0, cyc = 0;
  int          last_link = 0, link_per = 0, links = 0, n_err = 0, p0, p1;

  always #2 clk = ~clk;

  pstpc_top #(.SEQ_LEN(2), .FIFO_DEPTH(16)) u_dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bist_start(bist_start), .bist_active(bist_active),
    .rx_nibble_valid(rx_nibble_valid), .rx_nibble_error(rx_nibble_error),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_kind(tx_kind),
    .tx_nibble(tx_nibble), .cont_prbs_active(cont_prbs_active));
  pstpc_tx_partner u_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .stall(stall),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .taken(taken));

  // one step of the random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one register write
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    reg_addr = 5'h1B;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // one register read, answer noted for the monitor
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    rd_q.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  // stop the generator and forget leftover words
  task automatic flush();
    wr(16'h0000);
    repeat (60) @(negedge clk);
    tx_q.delete();
  endtask

  // run one link pattern and measure its period
  task automatic link_period(input logic [15:0] v, output int per);
    flush();
    links = 0;
    tx_q.push_back(pstpc_pkg::KIND_LINK);
    wr(v);
    for (int i = 0; i < 12000 && links < 3; i++) @(negedge clk);
    if (links < 3) begin
      failures++;
      final_report();
    end
    per = link_per;
  endtask

  // monitor: stream words at the edge, read answers just after it
  always @(posedge clk) begin
    cyc++;
    if (rst_n && tx_valid && tx_ready) begin
      if (tx_kind == 3'h3) begin
        link_per = cyc - last_link;
        last_link = cyc;
        links++;
      end
      if (tx_kind == 3'h0) begin
        check({12'h0, tx_nibble}, {12'h0, scr_r[3:0]});
        repeat (4) scr_r = {scr_r[13:0], scr_r[14] ^ scr_r[13]};
      end
      if (tx_q.size() > 0) begin
        check({13'h0, tx_kind}, {13'h0, tx_q.pop_front()});
        if (tx_kind !== 3'h0) check({12'h0, tx_nibble}, 16'h000F);
      end
    end
    #1;
    if (rd_pend) check(reg_rdata, rd_q.pop_front());
    rd_pend = reg_rd;
  end

  // cut a hang short
  initial begin
    #400000;
    failures++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd(5'h1B, 16'h0000);
    wr(16'hFF00); // read-only count field only, reserved bits zero
    rd(5'h1B, 16'h0000);
    rd(5'h1A, 16'h0000);
    wr(16'h0026); // reserved bits zero
    rd(5'h1B, 16'h0026);
    wr(16'h0000);
    // random errors, some outside self test
    bist_active = 1'b1;
    bist_start = 1'b1;
    @(negedge clk);
    bist_start = 1'b0;
    for (int i = 0; i < 40; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      rx_nibble_valid = lfsr_r[1];
      rx_nibble_error = lfsr_r[0];
      bist_active = (i < 30);
      if (lfsr_r[1] && lfsr_r[0] && i < 30) n_err++;
      @(negedge clk);
    end
    rx_nibble_valid = 1'b0;
    bist_active = 1'b1;
    rd(5'h1B, {n_err[7:0], 8'h00});
    rx_nibble_valid = 1'b1;
    rx_nibble_error = 1'b1;
    repeat (300) @(negedge clk);
    rx_nibble_valid = 1'b0;
    rd(5'h1B, 16'hFF00);
    rx_nibble_valid = 1'b1;
    bist_start = 1'b1;
    @(negedge clk);
    bist_start = 1'b0;
    rx_nibble_valid = 1'b0;
    rd(5'h1B, 16'h0000);
    // continuous stream, jabber guard taken as disabled
    wr(16'h0020);
    repeat (20) @(negedge clk);
    check({15'h0, cont_prbs_active}, 16'h0001);
    repeat (20) tx_q.push_back(pstpc_pkg::KIND_DATA);
    p0 = taken;
    repeat (40) @(negedge clk);
    check(16'(taken - p0), 16'h0028);
    bist_active = 1'b0;
    repeat (3) @(negedge clk);
    check({15'h0, cont_prbs_active}, 16'h0000);
    bist_active = 1'b1;
    wr(16'h0030);
    repeat (3) @(negedge clk);
    check({15'h0, cont_prbs_active}, 16'h0000);
    bist_active = 1'b0;
    flush();
    // tone with a slow, then stalled, transmitter
    repeat (30) tx_q.push_back(pstpc_pkg::KIND_ONES);
    wr(16'h0013);
    slow = 1'b1;
    repeat (50) @(negedge clk);
    stall = 1'b1;
    repeat (40) @(negedge clk);
    stall = 1'b0;
    slow = 1'b0;
    repeat (60) @(negedge clk);
    check(16'(tx_q.size()), 16'h0000);
    // both data sequence forms
    for (int s = 0; s < 2; s++) begin
      flush();
      tx_q = '{3'h0, 3'h0, 3'(1 + s)};
      wr(16'h0010 | 16'(s));
      repeat (100) @(negedge clk);
      check(16'(tx_q.size()), 16'h0000);
    end
    // gap length for both settings
    link_period(16'h0012, p0);
    check(16'(p0), 16'h09C6);
    link_period(16'h0016, p1);
    check(16'(p1 - p0), 16'h04E2);
    flush();
    final_report();
  end
endmodule // test_packet_self_test_pattern_control
